/* design/mpsm_power_mgmt.sv */
// Power and system management: buttons, sleep states, carrier reset and card-mode pins.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "mpsm_regs.svh"
module mpsm_power_mgmt
  import mpsm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hsel,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_power_button_in_n,
  input wire logic i_reset_button_in_n,
  input wire logic i_supply_good_in,
  input wire logic i_undervoltage,
  input wire logic i_watchdog_timeout,
  input wire logic i_pcie_wake_in_n,
  input wire logic i_general_wake_in_n,
  input wire logic i_battery_low_in_n,
  input wire logic i_over_temp_in_n,
  input wire logic i_smbus_alert_in_n,
  input wire logic i_lid_in_n,
  input wire logic i_sleep_button_in_n,
  input wire logic i_card_clock,
  input wire logic i_card_command,
  input wire logic [3:0] i_card_data_out,
  input wire logic [3:0] i_card_data_oe,
  output logic [3:0] o_card_data_in,
  output logic o_card_write_protect,
  output logic o_card_detect,
  output logic o_carrier_reset_out_n,
  output logic o_suspend_pending_out_n,
  output logic o_suspend_to_ram_out_n,
  output logic o_suspend_to_disk_out_n,
  output logic o_soft_off_out_n,
  output logic o_thermal_shutdown_out_n,
  output logic o_system_mgmt_interrupt_n,
  output logic [1:0] o_gp_out_low,
  input wire logic [1:0] i_gp_out_high,
  output logic [1:0] o_gp_out_high,
  output logic [1:0] o_gp_out_high_oe,
  input wire logic [3:0] i_gp_in,
  output logic [3:0] o_gp_in,
  output logic [3:0] o_gp_in_oe
);
  localparam int NSYNC = 16;
  localparam int RST_W = $clog2(`MPSM_RESET_CYCLES + 1);
  localparam int PEND_W = $clog2(`MPSM_PENDING_CYCLES + 1);

  // Synchroniser inputs, packed so one generate loop covers them all.
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_c;
  assign raw_in = {i_gp_out_high, i_gp_in, i_sleep_button_in_n, i_lid_in_n,
                   i_smbus_alert_in_n, i_over_temp_in_n, i_battery_low_in_n,
                   i_general_wake_in_n, i_pcie_wake_in_n, i_supply_good_in,
                   i_reset_button_in_n, i_power_button_in_n};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      // Inputs idle high (pull-ups), so reset loads ones to avoid false edges.
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          sync_a[g] <= 1'b1;
          sync_b[g] <= 1'b1;
          sync_c[g] <= 1'b1;
        end else begin
          sync_a[g] <= raw_in[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
        end
      end
    end
  endgenerate

  wire power_button_in_n_rise = sync_b[0] & ~sync_c[0];
  wire rstbtn_fall = ~sync_b[1] & sync_c[1];
  wire supply_bad = ~sync_b[2];
  wire pcie_wake = ~sync_b[3] & sync_c[3];
  wire gen_wake = ~sync_b[4] & sync_c[4];
  wire battery_low_in_n = ~sync_b[5];
  wire overtemp = ~sync_b[6];
  wire smbus_alert_in_n = ~sync_b[7];
  wire smb_fall = ~sync_b[7] & sync_c[7];
  wire lid_change = sync_b[8] ^ sync_c[8];
  wire sleep_press = ~sync_b[9] & sync_c[9];
  wire [3:0] gp_in_sync = sync_b[13:10];
  wire [1:0] card_wp_cd = sync_b[15:14];

  // AHB-Lite slave: one wait state on reads, none on writes, always OKAY.
  logic [11:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] ctrl;
  logic [`MPSM_EV_WIDTH-1:0] events;
  mpsm_state_t state;
  mpsm_state_t next_state;
  logic [RST_W-1:0] rst_cnt;
  logic [PEND_W-1:0] pend_cnt;
  logic [1:0] pend_target;

  wire take = i_hsel & i_hready & i_htrans[1];
  wire wr_ctrl = wr_q & (addr_q == `MPSM_ADDR_CTRL);
  wire wr_event = wr_q & (addr_q == `MPSM_ADDR_EVENT);
  wire card_mode = ctrl[`MPSM_CTRL_CARD_MODE];
  wire sw_reset = wr_ctrl & i_hwdata[`MPSM_CTRL_SW_RESET];
  wire sleep_req = wr_ctrl & i_hwdata[`MPSM_CTRL_SLEEP_RAM];
  wire off_req = wr_ctrl & i_hwdata[`MPSM_CTRL_SOFT_OFF];
  wire wake_any = pcie_wake | gen_wake | smb_fall | sleep_press;
  wire [31:0] status_word = {23'h000000, card_wp_cd, sync_b[8], supply_bad,
                             rst_cnt != '0, state};
  wire [31:0] gpio_word = {28'h0000000, gp_in_sync};
  wire [31:0] rd_mux = (addr_q == `MPSM_ADDR_CTRL) ? ctrl :
                       (addr_q == `MPSM_ADDR_STATUS) ? status_word :
                       (addr_q == `MPSM_ADDR_EVENT) ? {23'h000000, events} :
                       (addr_q == `MPSM_ADDR_GPIO) ? gpio_word : 32'h00000000;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      addr_q <= i_haddr[11:0];
      wr_q <= take & i_hwrite;
      rd_q <= take & ~i_hwrite;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_hrdata <= 32'h00000000;
    end else if (take & ~i_hwrite) begin
      o_hrdata <= 32'h00000000;
    end else if (rd_q) begin
      o_hrdata <= rd_mux;
    end
  end

  assign o_hreadyout = ~rd_q;
  assign o_hresp = 1'b0;

  // Only the mode bit is stored; the other control bits are write-one strobes.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ctrl <= `MPSM_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {28'h0000000, i_hwdata[`MPSM_CTRL_CARD_MODE], 3'b000};
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear.
  wire [`MPSM_EV_WIDTH-1:0] ev_set = {sleep_press, lid_change, smbus_alert_in_n, overtemp,
                                      battery_low_in_n, gen_wake, pcie_wake, rstbtn_fall,
                                      power_button_in_n_rise};
  wire [`MPSM_EV_WIDTH-1:0] ev_clr = wr_event ? i_hwdata[`MPSM_EV_WIDTH-1:0] : '0;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  assign o_system_mgmt_interrupt_n = ~events[`MPSM_EV_SMBUS_ALERT_IN_N];

  // Power state machine.
  always_comb begin
    next_state = state;
    unique case (state)
      MPSM_OFF: begin
        if (power_button_in_n_rise) begin
          next_state = MPSM_ON;
        end
      end
      MPSM_ON: begin
        if (sleep_req | off_req | sleep_press) begin
          next_state = MPSM_PENDING;
        end
      end
      MPSM_PENDING: begin
        if (pend_cnt == '0) begin
          next_state = pend_target[1] ? MPSM_OFF : MPSM_SLEEP;
        end
      end
      MPSM_SLEEP: begin
        if (wake_any | power_button_in_n_rise) begin
          next_state = MPSM_ON;
        end
      end
      default: next_state = MPSM_OFF;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= MPSM_OFF;
      pend_cnt <= '0;
      pend_target <= 2'b00;
    end else begin
      state <= next_state;
      if (state == MPSM_ON && next_state == MPSM_PENDING) begin
        pend_cnt <= PEND_W'(`MPSM_PENDING_CYCLES);
        pend_target <= off_req ? 2'b10 : 2'b01;
      end else if (pend_cnt != '0) begin
        pend_cnt <= pend_cnt - PEND_W'(1);
      end
    end
  end

  // One-shot reset pulse; a held-low button does not extend it.
  wire rst_cause = rstbtn_fall | supply_bad | i_undervoltage | i_watchdog_timeout | sw_reset;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rst_cnt <= '0;
    end else if (rst_cause) begin
      rst_cnt <= RST_W'(`MPSM_RESET_CYCLES);
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - RST_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_carrier_reset_out_n <= 1'b0;
      o_suspend_pending_out_n <= 1'b1;
      o_suspend_to_ram_out_n <= 1'b1;
      o_soft_off_out_n <= 1'b0;
    end else begin
      o_carrier_reset_out_n <= ~(rst_cause | (rst_cnt > RST_W'(1)));
      o_suspend_pending_out_n <= ~(next_state == MPSM_PENDING);
      o_suspend_to_ram_out_n <= ~(next_state == MPSM_SLEEP);
      o_soft_off_out_n <= ~(next_state == MPSM_OFF);
    end
  end

  assign o_suspend_to_disk_out_n = 1'b1;
  assign o_thermal_shutdown_out_n = 1'b1;

  // Pin muxing between general purpose and card mode.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_gp_out_low <= 2'b00;
      o_gp_out_high <= 2'b00;
      o_gp_in <= 4'h0;
      o_card_data_in <= 4'hF;
      o_card_write_protect <= 1'b0;
      o_card_detect <= 1'b0;
    end else begin
      o_gp_out_low <= card_mode ? {i_card_command, i_card_clock} : 2'b00;
      o_gp_out_high <= 2'b00;
      o_gp_in <= i_card_data_out;
      o_card_data_in <= gp_in_sync;
      o_card_write_protect <= card_mode & card_wp_cd[0];
      o_card_detect <= card_mode & card_wp_cd[1];
    end
  end
  assign o_gp_out_high_oe = card_mode ? 2'b00 : 2'b11;
  assign o_gp_in_oe = card_mode ? i_card_data_oe : 4'h0;

  // Assertions.
  a_off_needs_edge: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_OFF && !power_button_in_n_rise) |=> (state == MPSM_OFF))
    else $error("left soft-off without a power-button edge");
  a_reset_pulse_ends: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (rstbtn_fall && !supply_bad && !i_undervoltage && !i_watchdog_timeout) ##1
    (!sync_b[1] && !supply_bad && !i_undervoltage && !i_watchdog_timeout && !wr_q)[*8]
    |-> ##[1:300] o_carrier_reset_out_n)
    else $error("carrier reset held by a low reset button");
  a_reset_on_cause: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    rst_cause |=> !o_carrier_reset_out_n)
    else $error("carrier reset missing after a cause");
  a_supply_bad_reset: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    $fell(sync_b[2]) |=> !o_carrier_reset_out_n)
    else $error("supply loss did not reset the carrier");
  a_pending_first: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_ON && next_state == MPSM_PENDING) |=> !o_suspend_pending_out_n ##1
    o_suspend_to_ram_out_n)
    else $error("suspend entered without prior notice");
  a_ram_level: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_suspend_to_ram_out_n == (state != MPSM_SLEEP))
    else $error("suspend-to-RAM output disagrees with state");
  a_off_level: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_soft_off_out_n == (state != MPSM_OFF))
    else $error("soft-off output disagrees with state");
  a_wake_resume: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_SLEEP && pcie_wake) |=> (state == MPSM_ON) ##0 o_suspend_to_ram_out_n)
    else $error("wake did not resume from sleep");
  a_smi_sticky: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    smbus_alert_in_n |=> !o_system_mgmt_interrupt_n)
    else $error("SMBus alert did not raise the interrupt");
  a_card_pins: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    card_mode |=> (o_gp_out_low == {$past(i_card_command), $past(i_card_clock)}))
    else $error("card clock or command not routed");
  // The unsupported outputs are tied off, so a carrier that waits for them to fall
  // would wait forever; the checks below keep them and the event latches honest.
  a_rise_leaves_off: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_OFF && power_button_in_n_rise) |=> (state == MPSM_ON && o_soft_off_out_n))
    else $error("power-button edge did not leave soft-off");
  a_low_button_free: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!rst_cause && rst_cnt <= RST_W'(1)) |=> o_carrier_reset_out_n)
    else $error("carrier reset held without a fresh cause");
  a_supply_level: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    supply_bad |=> !o_carrier_reset_out_n)
    else $error("carrier reset released while supply is bad");
  a_pend_notice: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_PENDING && pend_cnt != '0) |-> !o_suspend_pending_out_n)
    else $error("suspend notice missing while pending");
  a_disk_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_suspend_to_disk_out_n)
    else $error("suspend-to-disk output asserted");
  a_gen_wake: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_SLEEP && gen_wake) |=> (state == MPSM_ON))
    else $error("general wake did not resume from sleep");
  a_battery_low_in_n_event: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    battery_low_in_n |=> events[`MPSM_EV_BATTERY_LOW_IN_N])
    else $error("battery-low event not latched");
  a_overtemp_event: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    overtemp |=> events[`MPSM_EV_OVERTEMP])
    else $error("over-temperature event not latched");
  a_lid_event: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    lid_change |=> events[`MPSM_EV_LID])
    else $error("lid change event not latched");
  a_sleep_button: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (state == MPSM_ON && sleep_press) |=> (state == MPSM_PENDING))
    else $error("sleep button did not start a suspend");
  a_trip_idle: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_thermal_shutdown_out_n)
    else $error("thermal-shutdown output asserted");
  a_gp_pulled_up: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !card_mode |-> (o_gp_in_oe == 4'h0))
    else $error("general inputs driven outside card mode");
  a_card_inputs: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !card_mode |=> (!o_card_write_protect && !o_card_detect))
    else $error("card socket inputs passed outside card mode");
  a_card_data: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_card_data_in == $past(gp_in_sync))
    else $error("card data lines not passed through");
  a_sync_depth: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    sync_b == $past(sync_a))
    else $error("synchroniser stage skipped");
endmodule : mpsm_power_mgmt
`default_nettype wire

/* design/mpsm_regs.svh */
// Register offsets, field positions, reset values and timing counts of the power manager.
`ifndef MPSM_REGS_SVH
`define MPSM_REGS_SVH
`define MPSM_ADDR_CTRL 12'h000
`define MPSM_ADDR_STATUS 12'h004
`define MPSM_ADDR_EVENT 12'h008
`define MPSM_ADDR_GPIO 12'h00C
`define MPSM_CTRL_SLEEP_RAM 0
`define MPSM_CTRL_SOFT_OFF 1
`define MPSM_CTRL_SW_RESET 2
`define MPSM_CTRL_CARD_MODE 3
`define MPSM_CTRL_RESET 32'h00000000
`define MPSM_EV_POWER_BUTTON_IN_N 0
`define MPSM_EV_RSTBTN 1
`define MPSM_EV_PCIE_WAKE 2
`define MPSM_EV_GEN_WAKE 3
`define MPSM_EV_BATTERY_LOW_IN_N 4
`define MPSM_EV_OVERTEMP 5
`define MPSM_EV_SMBUS_ALERT_IN_N 6
`define MPSM_EV_LID 7
`define MPSM_EV_SLEEP_BTN 8
`define MPSM_EV_WIDTH 9
`define MPSM_RESET_PULSE_NS 1000
`define MPSM_RESET_CYCLES ((`MPSM_RESET_PULSE_NS + 4) / 5)
`define MPSM_PENDING_NS 100
`define MPSM_PENDING_CYCLES ((`MPSM_PENDING_NS + 4) / 5)
`endif

/* design/mpsm_pkg.sv */
// Types shared by the power and system management block.
package mpsm_pkg;
  typedef enum logic [3:0] {
    MPSM_OFF = 4'b0001,
    MPSM_ON = 4'b0010,
    MPSM_PENDING = 4'b0100,
    MPSM_SLEEP = 4'b1000
  } mpsm_state_t;
endpackage : mpsm_pkg

/* dv/mpsm_carrier_model.sv */
// Carrier side of the shared pins: pull-ups, card socket signals and card data lines.
`timescale 1ns/100ps
`default_nettype none
module mpsm_carrier_model (
  input wire logic [3:0] i_dev_data,
  input wire logic [3:0] i_dev_data_oe,
  input wire logic [1:0] i_dev_high,
  input wire logic [1:0] i_dev_high_oe,
  input wire logic i_card_present,
  input wire logic [3:0] i_card_data,
  input wire logic [3:0] i_card_data_oe,
  input wire logic i_write_protect,
  input wire logic i_detect,
  output logic [3:0] o_data_level,
  output logic [1:0] o_high_level
);
  // A line nobody drives floats up through the module pull-up.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      o_data_level[b] = i_dev_data_oe[b] ? i_dev_data[b] :
        ((i_card_present && i_card_data_oe[b]) ? i_card_data[b] : 1'b1);
    end
  end
  // The socket drives write-protect and detect back into the device.
  assign o_high_level = i_dev_high_oe & i_dev_high |
    ~i_dev_high_oe & (i_card_present ? {i_detect, i_write_protect} : 2'b10);
endmodule : mpsm_carrier_model
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the power and system management block.
`timescale 1ns/100ps
`default_nettype none
`include "mpsm_regs.svh"
module tb;
  import mpsm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hsel = 1'b0, hready, hresp;
  logic pwr_n = 1'b1, rst_n = 1'b1, good = 1'b1, uv = 1'b0, wdt = 1'b0;
  // Active-low sources: pcie wake, general wake, battery, temperature, alert, lid, sleep.
  logic [6:0] src_n = 7'h7F;
  logic cclk = 1'b0, ccmd = 1'b0, card = 1'b0, wp = 1'b0, det = 1'b0;
  logic [3:0] cdo = 4'h0, cdoe = 4'h0, sdata = 4'h0, sdoe = 4'h0;
  logic [3:0] gpi, gpi_dev, gpi_oe, cdin;
  logic [1:0] gpl, gph, gph_dev, gph_oe;
  logic cwp, ccd, crst_n, pend_n, ram_n, disk_n, off_n, trip_n, smi_n;
  int mismatches = 0;
  int n_compared = 0;
  int wk[4] = '{0, 1, 4, 6};
  always #2.5 clk = ~clk;
  mpsm_power_mgmt mpsm_power_mgmt_inst (
    .i_ref_clk(clk), .i_srst(srst), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hsel(hsel), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_power_button_in_n(pwr_n),
    .i_reset_button_in_n(rst_n), .i_supply_good_in(good), .i_undervoltage(uv),
    .i_watchdog_timeout(wdt), .i_pcie_wake_in_n(src_n[0]), .i_general_wake_in_n(src_n[1]),
    .i_battery_low_in_n(src_n[2]), .i_over_temp_in_n(src_n[3]), .i_smbus_alert_in_n(src_n[4]),
    .i_lid_in_n(src_n[5]), .i_sleep_button_in_n(src_n[6]), .i_card_clock(cclk),
    .i_card_command(ccmd), .i_card_data_out(cdo), .i_card_data_oe(cdoe), .o_card_data_in(cdin),
    .o_card_write_protect(cwp), .o_card_detect(ccd), .o_carrier_reset_out_n(crst_n),
    .o_suspend_pending_out_n(pend_n), .o_suspend_to_ram_out_n(ram_n),
    .o_suspend_to_disk_out_n(disk_n), .o_soft_off_out_n(off_n), .o_thermal_shutdown_out_n(trip_n),
    .o_system_mgmt_interrupt_n(smi_n), .o_gp_out_low(gpl), .i_gp_out_high(gph),
    .o_gp_out_high(gph_dev), .o_gp_out_high_oe(gph_oe), .i_gp_in(gpi), .o_gp_in(gpi_dev),
    .o_gp_in_oe(gpi_oe));
  mpsm_carrier_model mpsm_carrier_model_inst (
    .i_dev_data(gpi_dev), .i_dev_data_oe(gpi_oe), .i_dev_high(gph_dev), .i_dev_high_oe(gph_oe),
    .i_card_present(card), .i_card_data(sdata), .i_card_data_oe(sdoe), .i_write_protect(wp),
    .i_detect(det), .o_data_level(gpi), .o_high_level(gph));
  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Ready and read data are looked at just before the edge that samples them.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic r;
    htrans <= 2'h2;
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= a;
    do begin
      @(negedge clk);
      r = hready;
      @(posedge clk);
    end while (r !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(negedge clk);
      r = hready;
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      @(posedge clk);
    end while (r !== 1'b1);
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp,
                    input logic [31:0] mask);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q & mask);
  endtask : rd
  task automatic t_idle;
    chk("idle off ram", 32'h1, {off_n, ram_n});
    chk("idle unsupported", 32'h3, {disk_n, trip_n});
    chk("idle reset pend", 32'h3, {crst_n, pend_n});
    rd("status", `MPSM_ADDR_STATUS, 32'h01, 32'h3F);
    rd("gpio pull-ups", `MPSM_ADDR_GPIO, 32'hF, 32'hF);
    rd("unmapped", 32'h0000_0010, 32'h0, 32'hFFFF_FFFF);
  endtask : t_idle
  task automatic t_power_on;
    pwr_n <= 1'b0;
    cyc(10);
    chk("off on low level", 32'h0, off_n);
    pwr_n <= 1'b1;
    cyc(6);
    chk("on after rise", 32'h1, off_n);
    rd("state on", `MPSM_ADDR_STATUS, MPSM_ON, 32'hF);
  endtask : t_power_on
  task automatic t_sleep_wake;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        src_n[6] <= 1'b0;
        cyc(6);
        src_n[6] <= 1'b1;
      end else begin
        wr(`MPSM_ADDR_CTRL, 32'h1);
        cyc(3);
      end
      chk("pending first", 32'h1, {pend_n, ram_n});
      cyc(25);
      chk("in ram sleep", 32'h2, {pend_n, ram_n});
      rd("state sleep", `MPSM_ADDR_STATUS, MPSM_SLEEP, 32'hF);
      src_n[wk[i]] <= 1'b0;
      cyc(8);
      src_n <= 7'h7F;
      chk("woken", 32'h1, ram_n);
      cyc(6);
    end
  endtask : t_sleep_wake
  task automatic t_soft_off;
    wr(`MPSM_ADDR_CTRL, 32'h2);
    cyc(30);
    chk("soft off pins", 32'h1, {off_n, ram_n});
  endtask : t_soft_off
  task automatic t_events;
    wr(`MPSM_ADDR_EVENT, 32'h1FF);
    cyc(2);
    chk("smi idle", 32'h1, smi_n);
    src_n <= 7'h53;
    cyc(6);
    rd("level events", `MPSM_ADDR_EVENT, 32'hB0, 32'hF0);
    rd("lid level", `MPSM_ADDR_STATUS, 32'h0, 32'h40);
    src_n <= 7'h43;
    cyc(6);
    chk("smi on alert", 32'h0, smi_n);
    src_n <= 7'h7F;
    cyc(6);
    wr(`MPSM_ADDR_EVENT, 32'h1FF);
    cyc(2);
    chk("smi cleared", 32'h1, smi_n);
    rd("events clear", `MPSM_ADDR_EVENT, 32'h0, 32'h1FF);
  endtask : t_events
  task automatic cause(input int i, input logic on);
    case (i)
      0: rst_n <= ~on;
      1: good <= ~on;
      2: uv <= on;
      3: wdt <= on;
      default: if (on) wr(`MPSM_ADDR_CTRL, 32'h4);
    endcase
  endtask : cause
  task automatic t_resets;
    for (int i = 0; i < 5; i++) begin
      cause(i, 1'b1);
      cyc(6);
      chk("reset asserted", 32'h0, crst_n);
      if (i != 0) cause(i, 1'b0);
      cyc(180);
      chk("reset pulse", 32'h0, crst_n);
      cyc(30);
      chk("reset ended", 32'h1, crst_n);
      cause(i, 1'b0);
      cyc(5);
    end
  endtask : t_resets
  task automatic t_card(input logic [5:0] pins, input logic [11:0] drv, input logic [3:0] exp);
    {cclk, ccmd, wp, det, card} <= pins[4:0];
    {sdata, sdoe, cdoe} <= drv;
    cdo <= 4'h3;
    cyc(6);
    chk("card clock cmd", {ccmd, cclk}, gpl);
    chk("card wp cd", {det, wp}, {ccd, cwp});
    chk("card dir", {2'b00, cdoe}, {gph_oe, gpi_oe});
    chk("card data in", exp, cdin);
    rd("card pins status", `MPSM_ADDR_STATUS, {23'h0, det, wp, 7'h0}, 32'h180);
  endtask : t_card
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial begin
    cyc(10);
    srst <= 1'b0;
    cyc(4);
    t_idle;
    t_power_on;
    t_sleep_wake;
    t_soft_off;
    t_power_on;
    t_events;
    t_resets;
    chk("gp mode dir", 32'h30, {gph_oe, gpi_oe});
    chk("gp mode outs", 32'h0, {gpl, gph});
    wr(`MPSM_ADDR_CTRL, 32'h8);
    t_card(6'h0B, 12'hAF0, 4'hA);
    t_card(6'h15, 12'h005, 4'hB);
    rd("card mode bit", `MPSM_ADDR_CTRL, 32'h8, 32'hF);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
